/* design/fpi_fifo.sv */
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: Depth is a power of two.
// Notes: Full drops ready on the fill side; empty drops valid.

`timescale 1ns/1ps

module fpi_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   fpi_stream_if.snk s_in,
   fpi_stream_if.src s_out
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign s_in.ready = (count != (AW+1)'(D));
   assign s_out.valid = (count != '0);
   assign s_out.data = mem[rd_ptr];
   assign push = s_in.valid & s_in.ready;
   assign pop = s_out.valid & s_out.ready;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= s_in.data;
      end
   end

   // ----------------------------------------------------------------
   // Pointers and fill level
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

/* design/fpi_pins.sv */
// Purpose: Pin-level front end of a serial NOR flash: clock capture,
//    read launch with strobe, lane roles, resets and open-drain outputs.
// Assumes: Link clock at most a quarter of the reference clock rate.
// Notes: Open-drain pins drive low only; the pad pull-ups give high.
//
// Behaviour
// R1: In x1 mode sample command, address and data on rising clock edges.
// R2: In x1 mode change output data on falling clock edges.
// R3: In octal single-ended mode capture on both rising and falling edges.
// R4: In complementary mode capture at each true/complement crossing.
// R5: In single-ended mode the complement clock is ignored entirely.
// R6: Read strobe used only for reads, toggles with data while selected.
// R7: Octal read data launches edge-aligned with strobe transitions.
// R8: In x1 mode lane 0 is input only, lane 1 output only.
// R9: In octal mode all eight lanes carry data both ways.
// R10: Hardware reset low reinitialises and returns to array read.
// R11: Hardware reset low puts strobe and data lanes in high impedance.
// R12: An unconnected hardware reset input counts as inactive high.
// R13: Event output pulled low when an internal event occurs.
// R14: Reset output low during power-on reset, released after timeout.
// R15: On reset output release the device enters standby at once.
// R16: While reset output is low, ignore select and drive nothing else.
// R17: Interface clock may stop between transfers without harm.
// R18: Transactions start at select falling and end at select rising.
// R19: Select high means standby unless busy, inputs ignored, outputs off.

`timescale 1ns/1ps

module fpi_pins (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_clk_true,
   input wire logic i_clk_comp,
   input wire logic i_reset_pin_n,
   input wire logic [fpi_pkg::BYTE_W-1:0] i_dq_in,
   output logic [fpi_pkg::BYTE_W-1:0] o_dq_out,
   output logic [fpi_pkg::BYTE_W-1:0] o_dq_oe,
   output logic o_read_strobe,
   output logic o_read_strobe_oe,
   output logic o_event_n,
   output logic o_event_n_oe,
   output logic o_por_out_n,
   output logic o_por_out_n_oe,
   input wire logic i_octal_mode,
   input wire logic i_diff_clk,
   input wire logic i_read_active,
   input wire logic [fpi_pkg::BYTE_W-1:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic [fpi_pkg::BYTE_W-1:0] o_rx_data,
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   output logic o_cap_ready,
   output logic o_cap_drop,
   input wire logic i_embedded_busy,
   input wire logic i_event,
   input wire logic i_event_clear,
   input wire logic i_por_busy,
   input wire logic [fpi_pkg::POR_CNT_W-1:0] i_por_timeout,
   output logic o_standby,
   output logic o_frame_start,
   output logic o_frame_end,
   output logic o_core_reinit,
   output logic o_array_read
);
   logic [3:0] ctl_s;
   logic [3:0] ctl_rise;
   logic [3:0] ctl_fall;
   logic [fpi_pkg::BYTE_W-1:0] dq_s;
   logic rst_pin_s;
   logic cs_s;
   logic cs_fall;
   logic true_s;
   logic comp_s;
   logic hw_rst;
   logic cross_sign;
   logic cross_rise;
   logic cross_fall;
   logic edge_r;
   logic edge_f;
   fpi_pkg::fpi_por_e por_state;
   logic [fpi_pkg::POR_CNT_W-1:0] por_cnt;
   logic por_ok;
   fpi_pkg::fpi_lnk_e lnk_state;
   logic oct_mode;
   logic diff_mode;
   logic act;
   logic wr_phase;
   logic rd_phase;
   logic [fpi_pkg::BIT_CNT_W-1:0] rx_bit;
   logic [fpi_pkg::BYTE_W-2:0] rx_shift;
   logic cap_valid;
   logic [fpi_pkg::BYTE_W-1:0] cap_data;
   logic [fpi_pkg::BIT_CNT_W-1:0] tx_bit;
   logic [fpi_pkg::BYTE_W-1:0] tx_shift;
   logic launch;
   logic need_byte;
   logic tx_pop;
   logic drive_en;
   logic event_flag;

   fpi_stream_if #(.W(fpi_pkg::BYTE_W)) cap_if ();
   fpi_stream_if #(.W(fpi_pkg::BYTE_W)) rx_if ();

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   fpi_sync #(.W(4), .RST_VAL(fpi_pkg::CTL_SYNC_RST)) u_ctl_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async({i_reset_pin_n, i_cs_n, i_clk_comp, i_clk_true}),
      .o_level(ctl_s),
      .o_rise(ctl_rise),
      .o_fall(ctl_fall)
   );

   fpi_sync #(.W(fpi_pkg::BYTE_W), .RST_VAL(fpi_pkg::DQ_RST)) u_dq_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async(i_dq_in),
      .o_level(dq_s),
      .o_rise(),
      .o_fall()
   );

   // R12: pulled-up pin reads high; synchroniser resets to inactive.
   assign rst_pin_s = ctl_s[3];
   assign hw_rst = ~rst_pin_s;
   assign cs_s = ctl_s[2];
   assign cs_fall = ctl_fall[2];
   assign comp_s = ctl_s[1];
   assign true_s = ctl_s[0];

   // ----------------------------------------------------------------
   // Clock edge and crossing detection
   // ----------------------------------------------------------------
   // R4: crossing events from the sign of true against complement.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         cross_sign <= 1'b0;
      end else if (true_s != comp_s) begin
         cross_sign <= true_s;
      end
   end

   assign cross_rise = true_s & ~comp_s & ~cross_sign;
   assign cross_fall = ~true_s & comp_s & cross_sign;

   // R5: single-ended edges never look at the complement input.
   assign edge_r = diff_mode ? cross_rise : ctl_rise[0];
   assign edge_f = diff_mode ? cross_fall : ctl_fall[0];

   // ----------------------------------------------------------------
   // Power-on reset sequencing
   // ----------------------------------------------------------------
   // R14: hold while busy, then count the configured timeout.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         por_state <= fpi_pkg::POR_HOLD;
         por_cnt <= '0;
      end else begin
         case (por_state)
            fpi_pkg::POR_HOLD: begin
               if (!i_por_busy) begin
                  por_cnt <= i_por_timeout;
                  por_state <= fpi_pkg::POR_WAIT;
               end
            end
            fpi_pkg::POR_WAIT: begin
               if (i_por_busy) begin
                  por_state <= fpi_pkg::POR_HOLD;
               end else if (por_cnt == '0) begin
                  por_state <= fpi_pkg::POR_DONE;
               end else begin
                  por_cnt <= por_cnt - 1'b1;
               end
            end
            fpi_pkg::POR_DONE: begin
               if (i_por_busy) begin
                  por_state <= fpi_pkg::POR_HOLD;
               end
            end
            default: begin
               por_state <= fpi_pkg::POR_HOLD;
            end
         endcase
      end
   end

   assign por_ok = (por_state == fpi_pkg::POR_DONE);
   assign o_por_out_n = 1'b0;
   assign o_por_out_n_oe = ~por_ok;

   // ----------------------------------------------------------------
   // Transaction framing
   // ----------------------------------------------------------------
   // R18: a frame opens only on select falling and closes on it rising.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || hw_rst || !por_ok) begin
         lnk_state <= fpi_pkg::LNK_STANDBY;
         oct_mode <= 1'b0;
         diff_mode <= 1'b0;
         o_frame_start <= 1'b0;
         o_frame_end <= 1'b0;
      end else begin
         o_frame_start <= 1'b0;
         o_frame_end <= 1'b0;
         case (lnk_state)
            fpi_pkg::LNK_STANDBY: begin
               if (cs_fall) begin
                  lnk_state <= fpi_pkg::LNK_ACTIVE;
                  oct_mode <= i_octal_mode;
                  diff_mode <= i_diff_clk;
                  o_frame_start <= 1'b1;
               end
            end
            fpi_pkg::LNK_ACTIVE: begin
               // R19: select high returns the link to standby.
               if (cs_s) begin
                  lnk_state <= fpi_pkg::LNK_STANDBY;
                  o_frame_end <= 1'b1;
               end
            end
            default: begin
               lnk_state <= fpi_pkg::LNK_STANDBY;
            end
         endcase
      end
   end

   // R16: an unready device is never selected and takes nothing.
   assign act = (lnk_state == fpi_pkg::LNK_ACTIVE) & por_ok & ~hw_rst;
   assign wr_phase = act & ~i_read_active;
   assign rd_phase = act & i_read_active;
   // R15: released reset output leaves the link in standby.
   // R19: standby unless an embedded operation keeps the core busy.
   assign o_standby = (lnk_state == fpi_pkg::LNK_STANDBY) & por_ok
      & ~i_embedded_busy;

   // ----------------------------------------------------------------
   // Input capture
   // ----------------------------------------------------------------
   // R17: capture and launch state advances only on seen edges, so a stopped clock
   // simply freezes the capture and launch shifters.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || o_frame_start) begin
         rx_bit <= '0;
         rx_shift <= '0;
         cap_valid <= 1'b0;
         cap_data <= fpi_pkg::DQ_RST;
      end else begin
         cap_valid <= 1'b0;
         if (wr_phase && oct_mode && (edge_r || edge_f)) begin
            // R3: octal capture on both edges, one byte each.
            // R9: all eight lanes received.
            cap_data <= dq_s;
            cap_valid <= 1'b1;
         end else if (wr_phase && !oct_mode && edge_r) begin
            // R1: x1 sampling on the rising edge only.
            // R8: lane 0 is the serial input.
            rx_shift <= {rx_shift[fpi_pkg::BYTE_W-3:0], dq_s[fpi_pkg::SI_LANE]};
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == fpi_pkg::LAST_BIT) begin
               cap_data <= {rx_shift, dq_s[fpi_pkg::SI_LANE]};
               cap_valid <= 1'b1;
            end
         end
      end
   end

   assign cap_if.data = cap_data;
   assign cap_if.valid = cap_valid;
   assign o_cap_ready = cap_if.ready;

   // A byte offered to a full FIFO is lost; the flag holds to next frame.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_cap_drop <= 1'b0;
      end else if (cap_valid && !cap_if.ready) begin
         o_cap_drop <= 1'b1;
      end else if (o_frame_start) begin
         o_cap_drop <= 1'b0;
      end
   end

   fpi_fifo #(.W(fpi_pkg::BYTE_W), .D(fpi_pkg::FIFO_DEPTH)) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .s_in(cap_if),
      .s_out(rx_if)
   );

   assign o_rx_data = rx_if.data;
   assign o_rx_valid = rx_if.valid;
   assign rx_if.ready = i_rx_ready;

   // ----------------------------------------------------------------
   // Read data launch
   // ----------------------------------------------------------------
   // R2: x1 launches on falling edges.
   // R7: octal launches on every edge with the strobe.
   assign launch = rd_phase & (oct_mode ? (edge_r | edge_f) : edge_f);
   assign need_byte = oct_mode | (tx_bit == '0);
   assign tx_pop = launch & need_byte & i_tx_valid;
   assign o_tx_ready = tx_pop;

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || o_frame_start) begin
         tx_bit <= '0;
         tx_shift <= fpi_pkg::DQ_RST;
         o_dq_out <= fpi_pkg::DQ_RST;
         o_read_strobe <= 1'b0;
      end else if (tx_pop && oct_mode) begin
         // R7: data and strobe change in the same cycle.
         o_dq_out <= i_tx_data;
         o_read_strobe <= ~o_read_strobe;
      end else if (tx_pop) begin
         // R8: lane 1 carries the serial output, MSB first.
         tx_shift <= {i_tx_data[fpi_pkg::BYTE_W-2:0], 1'b0};
         o_dq_out <= {6'h00, i_tx_data[fpi_pkg::BYTE_W-1], 1'b0};
         o_read_strobe <= ~o_read_strobe;
         tx_bit <= tx_bit + 1'b1;
      end else if (launch && !need_byte) begin
         tx_shift <= {tx_shift[fpi_pkg::BYTE_W-2:0], 1'b0};
         o_dq_out <= {6'h00, tx_shift[fpi_pkg::BYTE_W-1], 1'b0};
         o_read_strobe <= ~o_read_strobe;
         tx_bit <= tx_bit + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Output enables
   // ----------------------------------------------------------------
   // R11: hardware reset clears the lane and strobe enables.
   // R6: the strobe is driven only in a read data phase.
   assign drive_en = rd_phase;

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || !drive_en) begin
         o_dq_oe <= '0;
         o_read_strobe_oe <= 1'b0;
      end else begin
         // R9: octal reads drive all lanes, x1 reads only lane 1.
         o_dq_oe <= oct_mode ? fpi_pkg::OE_OCTAL : fpi_pkg::OE_X1;
         o_read_strobe_oe <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Event output and hardware reset reporting
   // ----------------------------------------------------------------
   // R13: sticky event, a new event beats a clear in the same cycle.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn || hw_rst) begin
         event_flag <= 1'b0;
      end else if (i_event) begin
         event_flag <= 1'b1;
      end else if (i_event_clear) begin
         event_flag <= 1'b0;
      end
   end

   assign o_event_n = 1'b0;
   assign o_event_n_oe = event_flag & por_ok;

   // R10: reinitialise while low, array read on release.
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_core_reinit <= 1'b1;
         o_array_read <= 1'b0;
      end else begin
         o_core_reinit <= hw_rst;
         o_array_read <= ctl_rise[3];
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);

   chk_por_hold_out: assert property ( // R14
      $rose(i_por_busy) |=> o_por_out_n_oe [*2])
      else $error("reset output not held during power-on reset");

   chk_por_standby: assert property ( // R15
      por_state == fpi_pkg::POR_WAIT && por_cnt == '0 && !i_por_busy
      |=> !o_por_out_n_oe && lnk_state == fpi_pkg::LNK_STANDBY)
      else $error("release did not enter standby");

   chk_blocked_quiet: assert property ( // R16
      $past(!por_ok) |-> o_dq_oe == '0 && !o_read_strobe_oe
      && (por_ok || !o_event_n_oe))
      else $error("output driven while reset output low");

   chk_hw_rst_hiz: assert property ( // R11
      $past(hw_rst) |-> o_dq_oe == '0 && !o_read_strobe_oe)
      else $error("lanes driven during hardware reset");

   chk_x1_so_lane: assert property ( // R8
      !oct_mode && o_dq_oe != '0 |-> o_dq_oe == fpi_pkg::OE_X1)
      else $error("x1 read drives a lane other than lane 1");

   chk_octal_all_lanes: assert property ( // R9
      oct_mode && o_dq_oe != '0 |-> o_dq_oe == fpi_pkg::OE_OCTAL)
      else $error("octal read does not drive all lanes");

   chk_strobe_with_data: assert property ( // R7
      oct_mode && tx_pop |=> $changed(o_read_strobe)
      && o_dq_out == $past(i_tx_data))
      else $error("octal data not aligned with strobe");

   chk_x1_no_fall_cap: assert property ( // R1
      !oct_mode && edge_f |=> !cap_valid)
      else $error("x1 captured on a falling edge");

   chk_octal_fall_cap: assert property ( // R3
      wr_phase && oct_mode && edge_f |=> cap_valid
      && cap_data == $past(dq_s))
      else $error("octal falling edge not captured");

   chk_cs_frame_open: assert property ( // R18
      cs_fall && act == 1'b0 && por_ok && !hw_rst
      && lnk_state == fpi_pkg::LNK_STANDBY
      |=> lnk_state == fpi_pkg::LNK_ACTIVE && o_frame_start)
      else $error("select falling did not open a frame");

   chk_cs_high_off: assert property ( // R19
      lnk_state == fpi_pkg::LNK_ACTIVE && cs_s
      |=> lnk_state == fpi_pkg::LNK_STANDBY ##1 o_dq_oe == '0)
      else $error("select high did not release the lanes");

   chk_event_sticky: assert property ( // R13
      i_event && por_ok && !hw_rst ##1 por_ok |-> o_event_n_oe)
      else $error("event did not pull the event output");

   cov_x1_byte: cover property (!oct_mode && cap_valid);
   cov_octal_read: cover property (oct_mode && tx_pop ##[1:20] tx_pop);
   cov_por_release: cover property ($fell(o_por_out_n_oe));
   cov_event: cover property ($rose(o_event_n_oe));
endmodule

/* design/fpi_pkg.sv */
// Purpose: Shared constants and types of the flash pin interface block.
// Assumes: One reference clock; the link clock is sampled, not used as clock.
// Notes: Every number used by more than one file is named here once.

package fpi_pkg;

   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int BIT_CNT_W = 3;
   localparam int POR_CNT_W = 16;

   // ----------------------------------------------------------------
   // Lane roles and reset values
   // ----------------------------------------------------------------
   localparam int SI_LANE = 0;
   localparam int SO_LANE = 1;
   localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
   localparam logic [BYTE_W-1:0] DQ_RST = 8'h00;
   localparam logic [BYTE_W-1:0] OE_OCTAL = 8'hFF;
   localparam logic [BYTE_W-1:0] OE_X1 = 8'h02;
   localparam logic [3:0] CTL_SYNC_RST = 4'hC;

   // ----------------------------------------------------------------
   // State machines
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      POR_HOLD = 3'b001,
      POR_WAIT = 3'b010,
      POR_DONE = 3'b100
   } fpi_por_e;

   typedef enum logic [1:0] {
      LNK_STANDBY = 2'b01,
      LNK_ACTIVE = 2'b10
   } fpi_lnk_e;

endpackage

/* design/fpi_stream_if.sv */
// Purpose: Valid/ready stream carrier between the block's own modules.
// Assumes: Both ends run on the reference clock.
// Notes: A word moves on a cycle where valid and ready are both high.

`timescale 1ns/1ps

interface fpi_stream_if #(
   parameter int W = 8
);
   logic [W-1:0] data;
   logic valid;
   logic ready;

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

/* design/fpi_sync.sv */
// Purpose: Two-stage synchroniser with edge detection for pin inputs.
// Assumes: Inputs are asynchronous to the reference clock.
// Notes: The first stage feeds only the second stage.

`timescale 1ns/1ps

module fpi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise,
   output logic [W-1:0] o_fall
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   // ----------------------------------------------------------------
   // Synchroniser chain
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= i_async;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   assign o_level = stage2;
   assign o_rise = stage2 & ~stage3;
   assign o_fall = ~stage2 & stage3;
endmodule

/* dv/fpi_host.sv */
// Purpose: Host model driving select, link clocks and data lanes.
// Assumes: Link half period 80 ns; clocks stand still outside frames.
// Notes: Released lanes show the inverse of their last value.

`timescale 1ns/1ps

module fpi_host (
   output logic o_cs_n,
   output logic o_clk_true,
   output logic o_clk_comp,
   output logic [7:0] o_dq
);
   logic diff = 1'b0;

   initial begin
      o_cs_n = 1'b1;
      o_clk_true = 1'b0;
      o_clk_comp = 1'b1;
      o_dq = 8'h00;
   end

   task automatic frame(input logic on);
      if (diff)
         o_clk_comp <= ~o_clk_true;
      if (!on)
         o_dq <= ~o_dq;
      o_cs_n <= ~on;
      #200;
   endtask

   // Data set up before each edge.
   task automatic half(input logic [7:0] d);
      o_dq <= d;
      if (!diff)
         o_clk_comp <= ~o_clk_comp;
      #40;
      o_clk_true <= ~o_clk_true;
      if (diff)
         o_clk_comp <= o_clk_true;
      #40;
   endtask

   // Lane 0 carries x1 bits, MSB first.
   task automatic send_x1(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         half({7'h00, b[i]});
         half({7'h00, b[i]});
      end
   endtask
endmodule

/* dv/tb.sv */
// Purpose: Self-checking bench of the flash pin front end.
// Assumes: Host model makes the link clock at 160 ns.
// Notes: Random bytes come from an LFSR seeded with 64.

`timescale 1ns/1ps

module tb;
   logic clk, rstn, pin_n, oct, dif, rd, txv, rxr, emb, ev, evc, porb;
   logic stb_q = 1'b0;
   logic [7:0] txd, seed = 8'h40;
   logic [15:0] pto;
   logic [7:0] hdq, dq_out, dq_oe, rx_d;
   logic cs_n, ct, cc, stb, stb_oe, ev_oe, por_oe, txr, rxv, cap_r, cap_d;
   logic sb, fs, fe, arr, reinit;
   logic [7:0] q[$];
   int num_errors = 0, n_compared = 0, cyc = 0;
   int n_fs = 0, n_fe = 0, n_tx = 0, n_stb = 0, n_arr = 0, t0, s0;

   fpi_host host (.o_cs_n(cs_n), .o_clk_true(ct), .o_clk_comp(cc),
      .o_dq(hdq));
   fpi_pins dut (.i_ref_clk(clk), .i_resetn(rstn), .i_cs_n(cs_n),
      .i_clk_true(ct), .i_clk_comp(cc), .i_reset_pin_n(pin_n),
      .i_dq_in((dq_oe & dq_out) | (~dq_oe & hdq)), .o_dq_out(dq_out),
      .o_dq_oe(dq_oe), .o_read_strobe(stb), .o_read_strobe_oe(stb_oe),
      .o_event_n(), .o_event_n_oe(ev_oe), .o_por_out_n(),
      .o_por_out_n_oe(por_oe), .i_octal_mode(oct), .i_diff_clk(dif),
      .i_read_active(rd), .i_tx_data(txd), .i_tx_valid(txv),
      .o_tx_ready(txr), .o_rx_data(rx_d), .o_rx_valid(rxv),
      .i_rx_ready(rxr), .o_cap_ready(cap_r), .o_cap_drop(cap_d),
      .i_embedded_busy(emb), .i_event(ev), .i_event_clear(evc),
      .i_por_busy(porb), .i_por_timeout(pto), .o_standby(sb),
      .o_frame_start(fs), .o_frame_end(fe), .o_core_reinit(reinit),
      .o_array_read(arr));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   task automatic check(input string nm, input logic [15:0] exp,
                        input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic results();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic drain(input int n);
      for (int k = 0; k < n; k++) begin
         int w = 0;
         @(negedge clk);
         while (rxv !== 1'b1 && w < 60) begin
            @(negedge clk);
            w++;
         end
         check("rx_byte", q.pop_front(), rx_d);
         @(posedge clk);
         rxr <= 1'b1;
         @(posedge clk);
         rxr <= 1'b0;
      end
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      n_fs <= n_fs + int'(fs === 1'b1);
      n_fe <= n_fe + int'(fe === 1'b1);
      n_tx <= n_tx + int'(txr === 1'b1);
      n_arr <= n_arr + int'(arr === 1'b1);
      stb_q <= stb;
      n_stb <= n_stb + int'(stb !== stb_q);
      if (cyc == 30000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      {rstn, oct, dif, rd, txv, rxr, emb, ev, evc} <= '0;
      {pin_n, porb} <= 2'b11;
      txd <= 8'h00;
      pto <= 16'h0003;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      host.frame(1'b1);
      host.frame(1'b0);
      @(negedge clk);
      check("frames_in_por", 0, n_fs);
      check("dq_oe_in_por", 0, dq_oe);
      @(posedge clk);
      porb <= 1'b0;
      repeat (2) @(negedge clk);
      check("por_wait", 1, por_oe);
      repeat (8) @(negedge clk);
      check("por_done", 0, por_oe);
      check("standby", 1, sb);
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         oct <= (m != 0);
         dif <= (m == 2);
         host.diff = (m == 2);
         host.frame(1'b1);
         for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            q.push_back(seed);
            if (m == 0)
               host.send_x1(seed);
            else
               host.half(seed);
         end
         host.frame(1'b0);
         drain(2);
      end
      @(posedge clk);
      dif <= 1'b0;
      host.diff = 1'b0;
      host.frame(1'b1);
      for (int k = 0; k < 20; k++) begin
         seed = lfsr(seed);
         if (k < 16)
            q.push_back(seed);
         host.half(seed);
      end
      @(negedge clk);
      check("fifo_full", 0, cap_r);
      check("byte_lost", 1, cap_d);
      host.frame(1'b0);
      drain(16);
      @(negedge clk);
      check("fifo_empty", 0, rxv);
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         oct <= m[0];
         rd <= 1'b1;
         txv <= 1'b1;
         txd <= lfsr(seed);
         t0 = n_tx;
         s0 = n_stb;
         host.frame(1'b1);
         repeat (m ? 8 : 16) host.half(8'h00);
         @(negedge clk);
         check("lane_oe", m ? fpi_pkg::OE_OCTAL : fpi_pkg::OE_X1, dq_oe);
         if (m)
            check("strobe_oe", 1, stb_oe);
         host.frame(1'b0);
         check("bytes_taken", m ? 8 : 1, n_tx - t0);
         check("rd_data", m ? txd : {6'h00, txd[0], 1'b0}, dq_out);
         if (m)
            check("strobe_steps", 8, n_stb - s0);
         check("oe_off", 0, {stb_oe, dq_oe});
      end
      @(posedge clk);
      emb <= 1'b1;
      ev <= 1'b1;
      evc <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      evc <= 1'b0;
      repeat (2) @(negedge clk);
      check("event_low", 1, ev_oe);
      check("busy_no_standby", 0, sb);
      @(posedge clk);
      evc <= 1'b1;
      emb <= 1'b0;
      @(posedge clk);
      evc <= 1'b0;
      repeat (2) @(negedge clk);
      check("event_clear", 0, ev_oe);
      check("frame_ends", n_fs, n_fe);
      porb <= 1'b1;
      @(posedge clk);
      porb <= 1'b0;
      repeat (2) @(negedge clk);
      check("por_again", 1, por_oe);
      repeat (8) @(negedge clk);
      host.frame(1'b1);
      repeat (4) host.half(8'h00);
      @(posedge clk);
      pin_n <= 1'b0;
      t0 = n_arr;
      repeat (4) @(negedge clk);
      check("reinit", 1, reinit);
      check("hw_rst_oe", 0, {stb_oe, dq_oe});
      host.frame(1'b0);
      @(posedge clk);
      pin_n <= 1'b1;
      repeat (5) @(negedge clk);
      check("array_read", 1, n_arr - t0);
      results();
   end
endmodule
